// >>> ffmd_params.svh
// Register map, field positions and reset values of the freefall/motion detector.
// Assumes an 8-bit register bus with byte offsets as printed.
`ifndef FFMD_PARAMS_SVH
`define FFMD_PARAMS_SVH

`define FFMD_ADDR_CFG      8'h15
`define FFMD_ADDR_SRC      8'h16
`define FFMD_ADDR_THS      8'h17
`define FFMD_ADDR_CNT      8'h18
`define FFMD_ADDR_IRQ      8'h19

`define FFMD_CFG_LATCH     7
`define FFMD_CFG_OR_SEL    6
`define FFMD_CFG_EN_HI     5
`define FFMD_CFG_EN_LO     3
`define FFMD_SRC_ACTIVE    7
`define FFMD_THS_DBMODE    7
`define FFMD_IRQ_EN        0
`define FFMD_IRQ_ROUTE     1

`define FFMD_CFG_RESET     8'h00
`define FFMD_THS_RESET     8'h00
`define FFMD_CNT_RESET     8'h00
`define FFMD_IRQ_RESET     2'h0

`endif

// >>> ffmd_pkg.sv
// Types shared by the freefall/motion detector.
// Assumes the constants header is included alongside.
package ffmd_pkg;
  typedef logic [7:0] ffmd_byte_t;
  typedef logic [9:0] ffmd_sample_t;
endpackage

// >>> ffmd_detector.sv
// Freefall/motion event detector: per-axis threshold compare, debounce,
// latched or live source register, interrupt gating.
// Assumes a sample strobe from the data path once per output data rate and
// a register master that never issues read and write together.
// Assumes samples are two's complement and stand while the strobe is high;
// the register port answers every read in the following cycle, with no wait.
`timescale 1ns/1ps
`default_nettype none
`include "ffmd_params.svh"

module ffmd_detector #(
  parameter int SAMPLE_W = 10,
  parameter int THS_LSB  = 3
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Acceleration samples, two's complement, one strobe per sample
  input  wire logic                  sample_valid,
  input  wire ffmd_pkg::ffmd_sample_t accel_x,
  input  wire ffmd_pkg::ffmd_sample_t accel_y,
  input  wire ffmd_pkg::ffmd_sample_t accel_z,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire ffmd_pkg::ffmd_byte_t  reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [7:0]                 reg_rdata,
  // Interrupt routing
  output logic                       irq_pin1,
  output logic                       irq_pin2
);
  import ffmd_pkg::*;

  // Axes handled by the per-axis loop; index 0 is X, 2 is Z
  localparam int N_AXES = 3;

  // Software-visible registers
  ffmd_byte_t cfg_reg;
  ffmd_byte_t ths_reg;
  ffmd_byte_t cnt_reg;
  logic [1:0] irq_reg;

  // Debounce counter, event-active flag and per-axis flag pairs
  logic [7:0] dbc_reg;
  logic [7:0] dbc_next;
  logic [7:0] dbc_step;
  logic       active_reg;
  logic       active_next;
  logic [5:0] flags_reg;
  logic [5:0] flags_next;

  // Registered read data
  logic [7:0] rdata_reg;

  // Configuration fields
  wire        latch_en   = cfg_reg[`FFMD_CFG_LATCH];
  wire        or_sel     = cfg_reg[`FFMD_CFG_OR_SEL];
  wire [2:0]  axis_en    = cfg_reg[`FFMD_CFG_EN_HI:`FFMD_CFG_EN_LO];

  // Threshold fields
  wire        db_clear   = ths_reg[`FFMD_THS_DBMODE];
  wire [6:0]  threshold  = ths_reg[6:0];

  // Interrupt control fields
  wire        irq_enable = irq_reg[`FFMD_IRQ_EN];
  wire        irq_route  = irq_reg[`FFMD_IRQ_ROUTE];

  // Address decode
  wire        hit_cfg    = (reg_addr == `FFMD_ADDR_CFG);
  wire        hit_src    = (reg_addr == `FFMD_ADDR_SRC);
  wire        hit_ths    = (reg_addr == `FFMD_ADDR_THS);
  wire        hit_cnt    = (reg_addr == `FFMD_ADDR_CNT);
  wire        hit_irq    = (reg_addr == `FFMD_ADDR_IRQ);

  // The source register has no write strobe, so writes to it fall away
  wire        wr_cfg     = reg_write && hit_cfg;
  wire        wr_ths     = reg_write && hit_ths;
  wire        wr_cnt     = reg_write && hit_cnt;
  wire        wr_irq     = reg_write && hit_irq;
  wire        rd_src     = reg_read && hit_src;

  // Only a latched source register is cleared by reading it; in live mode
  // a read has no side effect at all
  wire        src_clear  = rd_src && latch_en;

  // Per-axis compare results and enable pairs
  wire [N_AXES-1:0]   axis_hi;
  wire [N_AXES-1:0]   axis_low;
  wire [N_AXES-1:0]   axis_neg;
  wire [N_AXES-1:0]   axis_evt;
  wire [5:0]          raw_flags;
  wire [5:0]          en_pairs;
  wire [SAMPLE_W-1:0] samples [N_AXES];
  wire [SAMPLE_W-1:0] thr_wide = SAMPLE_W'(threshold);

  assign samples[0] = accel_x;
  assign samples[1] = accel_y;
  assign samples[2] = accel_z;

  // Threshold counts are 0.063 g; the magnitude is shifted onto that scale,
  // by a fixed THS_LSB, so the compare does not adapt to the full-scale range
  genvar g;
  generate
    for (g = 0; g < N_AXES; g++) begin : g_axis
      wire [SAMPLE_W-1:0] s     = samples[g];
      wire                s_neg = s[SAMPLE_W-1];
      wire [SAMPLE_W-1:0] s_inv = SAMPLE_W'(-s);
      wire [SAMPLE_W-1:0] mag   = s_neg ? s_inv : s;
      wire [SAMPLE_W-1:0] mag_c = mag >> THS_LSB;

      // Strictly above is high g; at or below is low g
      assign axis_hi[g]  = (mag_c > thr_wide);
      assign axis_low[g] = !axis_hi[g];
      assign axis_neg[g] = s_neg;

      // Disabled axes never flag
      assign axis_evt[g] = (or_sel ? axis_hi[g] : axis_low[g]) && axis_en[g];

      // Flag in the upper bit of the pair, polarity in the lower
      assign raw_flags[2*g+1] = axis_evt[g];
      assign raw_flags[2*g]   = axis_neg[g] && axis_evt[g];
      assign en_pairs[2*g+1]  = axis_en[g];
      assign en_pairs[2*g]    = axis_en[g];
    end
  endgenerate

  // Combination of the enabled axes; with no axis enabled there is no
  // condition, even under AND, which is how the function is switched off
  wire        any_en     = (axis_en != 3'h0);
  wire        any_evt    = (axis_evt != 3'h0);
  wire        all_evt    = (axis_evt == axis_en);
  wire        comb_evt   = or_sel ? any_evt : all_evt;
  wire        cond       = any_en && comb_evt;

  // Debounce target and counter state
  wire [7:0]  cnt_limit  = cnt_reg;
  wire [7:0]  dbc_inc    = dbc_reg + 8'h01;
  wire [7:0]  dbc_dec    = dbc_reg - 8'h01;
  wire        below_lim  = (dbc_reg < cnt_limit);
  wire        dbc_zero   = (dbc_reg == 8'h00);

  // One counter step for the current sample. It saturates at the target, so a
  // long event never leaves a backlog that would delay the end of it
  always_comb begin
    dbc_step = dbc_reg;
    if (cond) begin
      if (below_lim) begin
        dbc_step = dbc_inc;
      end
    end else if (db_clear) begin
      dbc_step = 8'h00;
    end else if (!dbc_zero) begin
      dbc_step = dbc_dec;
    end
  end

  // The target counts as reached by the sample that brings the counter there;
  // a count of zero therefore flags on the first qualifying sample
  wire        target_hit = cond && (dbc_step >= cnt_limit);

  // Counter moves only on a sample; a latched source read clears it
  always_comb begin
    dbc_next = dbc_reg;
    if (sample_valid) begin
      dbc_next = dbc_step;
    end
    if (src_clear) begin
      dbc_next = 8'h00;
    end
  end

  // Event-active flag: sticky in latched mode, live otherwise. A source read
  // beats a same-cycle set, so the next event re-qualifies over the full delay
  always_comb begin
    active_next = active_reg;
    if (sample_valid) begin
      if (latch_en) begin
        if (!active_reg && target_hit) begin
          active_next = 1'b1;
        end
      end else begin
        active_next = target_hit;
      end
    end else if (!latch_en) begin
      active_next = active_reg && any_en;
    end
    if (src_clear) begin
      active_next = 1'b0;
    end
  end

  // Axis flags follow each sample while nothing is latched, and freeze with
  // the sample that sets the latched event-active flag
  wire        flags_open = !latch_en || !active_reg;

  always_comb begin
    flags_next = flags_reg;
    if (sample_valid) begin
      if (flags_open) begin
        flags_next = raw_flags;
      end
    end else if (!latch_en) begin
      flags_next = flags_reg & en_pairs;
    end
    if (src_clear) begin
      flags_next = 6'h00;
    end
  end

  // Next values of the software-visible registers
  wire [7:0]  cfg_next   = wr_cfg ? {reg_wdata[7:3], 3'h0} : cfg_reg;
  wire [7:0]  ths_next   = wr_ths ? reg_wdata : ths_reg;
  wire [7:0]  cnt_next   = wr_cnt ? reg_wdata : cnt_reg;
  wire [1:0]  irq_next   = wr_irq ? reg_wdata[1:0] : irq_reg;

  // Source register image; disabled axes are masked here as well, so a
  // latched pair reads zero as soon as its axis is switched off
  wire [5:0]  src_flags  = flags_reg & en_pairs;
  wire [7:0]  src_val    = {active_reg, 1'b0, src_flags};

  // Read multiplexer; unmapped addresses read zero
  wire [7:0]  rd_mux     = hit_cfg ? cfg_reg :
                           hit_src ? src_val :
                           hit_ths ? ths_reg :
                           hit_cnt ? cnt_reg :
                           hit_irq ? {6'h00, irq_reg} : 8'h00;

  // Read data stand for the one cycle after the strobe and are zero otherwise,
  // so a master that samples late sees zero rather than stale data
  wire [7:0]  rdata_next = reg_read ? rd_mux : 8'h00;

  // Configuration register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_reg <= `FFMD_CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Threshold register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ths_reg <= `FFMD_THS_RESET;
    end else begin
      ths_reg <= ths_next;
    end
  end

  // Debounce count register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= `FFMD_CNT_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Interrupt control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_reg <= `FFMD_IRQ_RESET;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Debounce counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dbc_reg <= 8'h00;
    end else begin
      dbc_reg <= dbc_next;
    end
  end

  // Event-active flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  // Axis flag pairs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags_reg <= 6'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Read data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Interrupt: route set selects pin 1, route clear selects pin 2. The pins
  // follow the event-active flag directly, so in latched mode they clear with the source read
  wire        irq_live   = active_reg && irq_enable;

  assign reg_rdata = rdata_reg;
  assign irq_pin1  = irq_live && irq_route;
  assign irq_pin2  = irq_live && !irq_route;

endmodule

`default_nettype wire

// >>> ffmd_properties.sv
// Port assertions of the freefall/motion detector.
// Assumes config at 0x15, source at 0x16, threshold at 0x17.
`timescale 1ns/1ps
`default_nettype none
module ffmd_properties (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  // Observed ports
  input wire logic                 sample_valid,
  input wire logic [7:0]           reg_addr,
  input wire ffmd_pkg::ffmd_byte_t reg_wdata,
  input wire logic                 reg_write,
  input wire logic                 reg_read,
  input wire logic [7:0]           reg_rdata,
  input wire logic                 irq_pin1,
  input wire logic                 irq_pin2
);
  import ffmd_pkg::*;
  logic [7:0]      cfg_reg;
  wire logic       rd_src = reg_read && reg_addr == 8'h16;
  wire logic [5:0] en_mask = {{2{cfg_reg[5]}}, {2{cfg_reg[4]}}, {2{cfg_reg[3]}}};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shadow of the config register, so latch and enable bits are known here
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_reg <= 8'h00;
    end else if (reg_write && reg_addr == 8'h15) begin
      cfg_reg <= reg_wdata;
    end
  end
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  src_bit6_a: assert property (rd_src |=> !reg_rdata[6])
    else $error("source bit 6 set");
  cfg_low_a: assert property (reg_read && reg_addr == 8'h15 |=> reg_rdata[2:0] == 3'h0)
    else $error("config low bits set");
  ths_rw_a: assert property (reg_write && reg_addr == 8'h17 ##1 reg_read && reg_addr == 8'h17
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("threshold readback wrong");
  src_clear_a: assert property (cfg_reg[7] && rd_src ##1 rd_src |=> reg_rdata == 8'h00)
    else $error("latched source not cleared");
  axis_mask_a: assert property (rd_src |=> (reg_rdata[5:0] & ~$past(en_mask)) == 6'h00)
    else $error("disabled axis flag set");
  irq_excl_a: assert property (!(irq_pin1 && irq_pin2))
    else $error("both interrupt pins high");
  irq_cause_a: assert property ($rose(irq_pin1) || $rose(irq_pin2)
    |-> $past(sample_valid || reg_write)) else $error("interrupt rose without cause");
  cover property (rd_src ##1 rd_src);
  cover property ($rose(irq_pin1));
  cover property ($rose(irq_pin2));
endmodule
bind ffmd_detector ffmd_properties chk (.clk(clk), .resetn(resetn), .sample_valid(sample_valid),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .irq_pin1(irq_pin1), .irq_pin2(irq_pin2));
`default_nettype wire

// >>> ffmd_detector_tb.sv
// Self-checking bench of the freefall/motion detector, driven at its ports.
// Assumes default sample width and a threshold step of eight sample counts.
`timescale 1ns/1ps
`default_nettype none
module ffmd_detector_tb;
  import ffmd_pkg::*;
  logic         clk = 1'b0, resetn = 1'b0, sample_valid = 1'b0;
  ffmd_sample_t accel_x = 10'h000, accel_y = 10'h000, accel_z = 10'h000;
  logic [7:0]   reg_addr = 8'h00, reg_rdata;
  ffmd_byte_t   reg_wdata = 8'h00;
  logic         reg_write = 1'b0, reg_read = 1'b0, irq_pin1, irq_pin2;
  int           errors = 0, n_checks = 0;
  always #20 clk = ~clk;
  ffmd_detector uut (.clk(clk), .resetn(resetn), .sample_valid(sample_valid), .accel_x(accel_x),
    .accel_y(accel_y), .accel_z(accel_z), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_pin1(irq_pin1),
    .irq_pin2(irq_pin2));
  task ck(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write or read, then a read right behind it with no gap
  task acc(input logic w, input logic [7:0] a, d, e1, e2);
    @(posedge clk);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(negedge clk);
    if (!w) ck("rdata first", e1, reg_rdata);
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    ck("rdata second", e2, reg_rdata);
  endtask
  // One sample; ip holds the expected {irq_pin2, irq_pin1} afterwards
  task smp(input logic [9:0] x, y, z, input logic [1:0] ip);
    @(posedge clk);
    sample_valid <= 1'b1;
    accel_x <= x;
    accel_y <= y;
    accel_z <= z;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(negedge clk);
    ck("irq pins", {6'h00, ip}, {6'h00, irq_pin2, irq_pin1});
  endtask
  task t_regs;
    for (int a = 'h15; a < 'h1a; a++) acc(1'b0, 8'(a), 8'h00, 8'h00, 8'h00);
    acc(1'b1, 8'h15, 8'hff, 8'h00, 8'hf8);
    acc(1'b1, 8'h17, 8'h85, 8'h00, 8'h85);
    acc(1'b1, 8'h16, 8'hff, 8'h00, 8'h00);
    acc(1'b1, 8'h20, 8'hff, 8'h00, 8'h00);
  endtask
  task t_latched;
    acc(1'b1, 8'h15, 8'hf8, 8'h00, 8'hf8);
    acc(1'b1, 8'h17, 8'h10, 8'h00, 8'h10);
    acc(1'b1, 8'h18, 8'h02, 8'h00, 8'h02);
    acc(1'b1, 8'h19, 8'h03, 8'h00, 8'h03);
    smp(10'h378, 10'h080, 10'h000, 2'h0);
    acc(1'b0, 8'h16, 8'h00, 8'h03, 8'h00);
    smp(10'h378, 10'h080, 10'h000, 2'h0);
    smp(10'h378, 10'h080, 10'h000, 2'h1);
    smp(10'h000, 10'h000, 10'h0c8, 2'h1);
    acc(1'b0, 8'h16, 8'h00, 8'h83, 8'h00);
    smp(10'h378, 10'h080, 10'h000, 2'h0);
  endtask
  // Freefall, live flags; z is disabled and far above the threshold
  task t_free;
    acc(1'b1, 8'h15, 8'h18, 8'h00, 8'h18);
    acc(1'b1, 8'h19, 8'h01, 8'h00, 8'h01);
    smp(10'h088, 10'h381, 10'h1f4, 2'h0);
    smp(10'h080, 10'h381, 10'h1f4, 2'h0);
    smp(10'h080, 10'h381, 10'h1f4, 2'h2);
    smp(10'h088, 10'h381, 10'h1f4, 2'h0);
    smp(10'h080, 10'h381, 10'h1f4, 2'h2);
    acc(1'b1, 8'h17, 8'h90, 8'h00, 8'h90);
    smp(10'h088, 10'h381, 10'h1f4, 2'h0);
    smp(10'h080, 10'h381, 10'h1f4, 2'h0);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_latched();
    t_free();
    finish_test();
  end
endmodule
`default_nettype wire
